// File: clp_pkg.sv
package clp_pkg;
  localparam int CLK_NS = 100;
  localparam int OFF_BASE_NS = 20000;
  localparam int OFF_STEP_NS = 1600;
  localparam int BLANK_STEP_NS = 400;
  localparam int OFF_BASE_CYC = (OFF_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_STEP_CYC = (OFF_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_ESF_BIT = 3;
  localparam int CTRL_RM_LSB = 4;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // configuration register fields
  localparam int CFG_ILIM_LSB = 0;
  localparam int CFG_OFF_LSB = 4;
  localparam int CFG_BLANK_LSB = 9;
  localparam logic [12:0] CFG_RESET = 13'h0000;

  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_INDIRECT = 2'h1;
  localparam logic [1:0] MODE_SPEED = 2'h2;
  localparam logic [1:0] MODE_CURRENT = 2'h3;

  localparam logic [1:0] RM_AUTO = 2'h0;
  localparam logic [1:0] RM_HIGH = 2'h1;
  localparam logic [1:0] RM_LOW = 2'h2;
  localparam logic [1:0] RM_FAST = 2'h3;

  localparam logic [2:0] PULSE_SHORT = 3'h2;
  localparam logic [2:0] PULSE_SYNC = 3'h3;
  localparam logic [2:0] PULSE_THERM = 3'h4;

  typedef enum logic [1:0] {BR_OFF, BR_DRIVE, BR_RECIRC, BR_WAIT} clp_br_e;
  typedef enum logic [1:0] {FP_IDLE, FP_LOW, FP_GAP} clp_fp_e;
endpackage

// File: clp_sync.sv
`timescale 1ns/1ps
module clp_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// File: clp_duty_div.sv
`timescale 1ns/1ps
module clp_duty_div #(
  parameter int W = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic [7:0] duty
);
  logic [W:0] rem_r, rem_nxt, rem_sh;
  logic [W-1:0] den_r, den_nxt;
  logic [7:0] q_r, q_nxt, duty_r, duty_nxt;
  logic [3:0] step_r, step_nxt;

  // restoring division, one quotient bit per clock: duty = num*256/den
  always_comb begin
    rem_nxt = rem_r;
    den_nxt = den_r;
    q_nxt = q_r;
    duty_nxt = duty_r;
    step_nxt = step_r;
    rem_sh = {rem_r[W-1:0], 1'b0};
    if (start) begin
      if (num >= den) begin
        duty_nxt = 8'hFF;
        step_nxt = 4'h0;
      end else begin
        rem_nxt = {1'b0, num};
        den_nxt = den;
        q_nxt = 8'h00;
        step_nxt = 4'h8;
      end
    end else if (step_r != 4'h0) begin
      if (rem_sh >= {1'b0, den_r}) begin
        rem_nxt = rem_sh - {1'b0, den_r};
        q_nxt = {q_r[6:0], 1'b1};
      end else begin
        rem_nxt = rem_sh;
        q_nxt = {q_r[6:0], 1'b0};
      end
      step_nxt = step_r - 4'h1;
      if (step_r == 4'h1) begin
        duty_nxt = q_nxt;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rem_r <= '0;
      den_r <= '0;
      q_r <= 8'h00;
      duty_r <= 8'h00;
      step_r <= 4'h0;
    end else begin
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      q_r <= q_nxt;
      duty_r <= duty_nxt;
      step_r <= step_nxt;
    end
  end

  assign duty = duty_r;
endmodule

// File: clp_current_limit.sv
`timescale 1ns/1ps
module clp_current_limit #(
  parameter int PER_W = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pwm_in,
  input wire logic ilim_cmp_in,
  input wire logic recirc_hs_pref,
  input wire logic fault_short,
  input wire logic fault_lost_sync,
  input wire logic fault_over_temp,
  input wire logic fault_temp_warn,
  input wire logic fault_undervolt,
  input wire logic serial_read_done,
  output logic bridge_drive,
  output logic recirc_high,
  output logic recirc_low,
  output logic recirc_fast,
  output logic gate_disable,
  output logic [3:0] ilim_threshold,
  output logic ds_blank,
  output logic fault_out_n_o,
  output logic fault_out_n_oe
);
  import clp_pkg::*;

  // pins from outside the clock domain
  logic pwm_s, cmp_s;
  clp_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({pwm_in, ilim_cmp_in}),
    .q({pwm_s, cmp_s})
  );

  // register file
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [12:0] cfg_r, cfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] mode, recirc_mode_field;
  logic run_en, stop_on_fault_bit;
  logic [3:0] ilim_level_field, blank_time_field;
  logic [4:0] off_time_field;

  assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
  assign run_en = ctrl_r[CTRL_RUN_BIT];
  assign stop_on_fault_bit = ctrl_r[CTRL_ESF_BIT];
  assign recirc_mode_field = ctrl_r[CTRL_RM_LSB +: 2];
  assign ilim_level_field = cfg_r[CFG_ILIM_LSB +: 4];
  assign off_time_field = cfg_r[CFG_OFF_LSB +: 5];
  assign blank_time_field = cfg_r[CFG_BLANK_LSB +: 4];

  // input period and duty measurement
  logic pwm_d_r;
  logic [PER_W-1:0] per_cnt_r, per_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
  logic pwm_rise, per_timeout, div_start, zero_pct;
  logic [PER_W-1:0] div_num, div_den;
  logic [7:0] duty8;
  localparam logic [PER_W-1:0] PER_MAX = '1;

  assign pwm_rise = pwm_s & ~pwm_d_r;
  assign per_timeout = (per_cnt_r == PER_MAX - 1'b1);
  assign zero_pct = (per_cnt_r == PER_MAX) & ~pwm_s;
  assign div_start = pwm_rise | per_timeout;
  // a stalled input reads as 0% or 100%
  assign div_num = pwm_rise ? hi_cnt_r : (pwm_s ? PER_MAX : '0);
  assign div_den = pwm_rise ? per_cnt_r : PER_MAX;

  always_comb begin
    per_cnt_nxt = per_cnt_r;
    hi_cnt_nxt = hi_cnt_r;
    if (pwm_rise) begin
      per_cnt_nxt = {{(PER_W-1){1'b0}}, 1'b1};
      hi_cnt_nxt = {{(PER_W-1){1'b0}}, 1'b1};
    end else if (per_cnt_r != PER_MAX) begin
      per_cnt_nxt = per_cnt_r + 1'b1;
      if (pwm_s) begin
        hi_cnt_nxt = hi_cnt_r + 1'b1;
      end
    end
  end

  clp_duty_div #(.W(PER_W)) u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(div_start),
    .num(div_num),
    .den(div_den),
    .duty(duty8)
  );

  // threshold and timing values
  logic [3:0] thr_nxt;
  logic [9:0] off_cycles;
  logic [5:0] blank_cycles;
  logic indirect, timed_off;

  assign indirect = (mode == MODE_INDIRECT) | (mode == MODE_SPEED);
  assign timed_off = (mode == MODE_DIRECT) | (mode == MODE_CURRENT);
  // upper duty nibble n gives (n+1) steps of 12.5 mV, up to 200 mV
  assign thr_nxt = (mode == MODE_CURRENT) ? duty8[7:4]
                                          : ilim_level_field;
  assign off_cycles = 10'(OFF_BASE_CYC) +
                      10'(off_time_field) * 10'(OFF_STEP_CYC);
  assign blank_cycles = 6'(blank_time_field) * 6'(BLANK_STEP_CYC);

  // fault latching and gate disable
  logic short_latch_r, short_latch_nxt;
  logic short_d_r, short_rise, gate_dis_nxt;

  assign short_rise = fault_short & ~short_d_r;

  always_comb begin
    short_latch_nxt = short_latch_r;
    if (zero_pct | serial_read_done) begin
      short_latch_nxt = 1'b0;
    end
    // a short in the clearing cycle still latches
    if (fault_short & stop_on_fault_bit) begin
      short_latch_nxt = 1'b1;
    end
  end

  assign gate_dis_nxt = fault_undervolt |
    (stop_on_fault_bit & (short_latch_nxt | fault_short |
     fault_lost_sync | fault_over_temp));

  // bridge PWM control
  clp_br_e br_r, br_nxt;
  logic [9:0] off_cnt_r, off_cnt_nxt, fix_cnt_r, fix_cnt_nxt;
  logic [5:0] blank_cnt_r, blank_cnt_nxt;
  logic period_tick, cycle_start, trip;

  assign period_tick = (fix_cnt_r == 10'h000);
  assign trip = cmp_s & (blank_cnt_r == 6'h00);

  always_comb begin
    unique case (mode)
      MODE_DIRECT: cycle_start = pwm_rise;
      MODE_CURRENT: cycle_start = 1'b1;
      default: cycle_start = period_tick;
    endcase
  end

  always_comb begin
    br_nxt = br_r;
    off_cnt_nxt = off_cnt_r;
    blank_cnt_nxt = blank_cnt_r;
    fix_cnt_nxt = period_tick ? off_cycles - 10'h001
                              : fix_cnt_r - 10'h001;
    if (blank_cnt_r != 6'h00) begin
      blank_cnt_nxt = blank_cnt_r - 6'h01;
    end
    if (!run_en | gate_dis_nxt) begin
      br_nxt = BR_OFF;
      blank_cnt_nxt = 6'h00;
    end else begin
      unique case (br_r)
        BR_OFF: br_nxt = BR_WAIT;
        BR_WAIT: begin
          if (cycle_start) begin
            br_nxt = BR_DRIVE;
            blank_cnt_nxt = blank_cycles;
          end
        end
        BR_DRIVE: begin
          if (trip) begin
            if (timed_off) begin
              br_nxt = BR_RECIRC;
              off_cnt_nxt = off_cycles;
            end else begin
              br_nxt = BR_WAIT;
            end
          end else if ((mode == MODE_DIRECT) & ~pwm_s) begin
            br_nxt = BR_WAIT;
          end
        end
        BR_RECIRC: begin
          off_cnt_nxt = off_cnt_r - 10'h001;
          if (off_cnt_r == 10'h001) begin
            // current mode restarts drive here, without waiting for a period tick
            if (mode == MODE_CURRENT) begin
              br_nxt = BR_DRIVE;
              blank_cnt_nxt = blank_cycles;
            end else begin
              br_nxt = BR_WAIT;
            end
          end
        end
      endcase
    end
  end

  // recirculation path while waiting or recirculating; none while off
  logic rec_on, hs_nxt, ls_nxt, fast_nxt;
  assign rec_on = (br_nxt == BR_RECIRC) | (br_nxt == BR_WAIT);

  always_comb begin
    hs_nxt = 1'b0;
    ls_nxt = 1'b0;
    fast_nxt = 1'b0;
    if (rec_on) begin
      unique case (recirc_mode_field)
        RM_HIGH: hs_nxt = 1'b1;
        RM_LOW: ls_nxt = 1'b1;
        RM_FAST: fast_nxt = 1'b1;
        RM_AUTO: begin
          hs_nxt = recirc_hs_pref;
          ls_nxt = ~recirc_hs_pref;
        end
      endcase
    end
  end

  // fault output pulse sequencer
  clp_fp_e fp_r, fp_nxt;
  logic [2:0] fp_len_r, fp_len_nxt, fp_cnt_r, fp_cnt_nxt;
  logic [2:0] req_len;
  logic req_rep, req_new, req_hold, perm_low, direct_low, oe_nxt;

  assign direct_low = fault_short | fault_lost_sync | fault_over_temp |
                      fault_temp_warn | fault_undervolt | short_latch_r;
  assign perm_low = fault_undervolt |
                    (fault_over_temp & stop_on_fault_bit);

  always_comb begin
    req_len = PULSE_SHORT;
    req_rep = 1'b0;
    req_new = 1'b0;
    if (short_rise | short_latch_r) begin
      req_len = PULSE_SHORT;
      req_rep = stop_on_fault_bit;
      req_new = short_rise | short_latch_r;
    end else if (fault_lost_sync) begin
      req_len = PULSE_SYNC;
      req_rep = 1'b1;
      req_new = 1'b1;
    end else if ((fault_over_temp & ~stop_on_fault_bit) |
                 (fault_temp_warn & stop_on_fault_bit)) begin
      req_len = PULSE_THERM;
      req_rep = 1'b1;
      req_new = 1'b1;
    end
  end

  // repetition continues while the starting fault persists
  always_comb begin
    unique case (fp_len_r)
      PULSE_SHORT: req_hold = short_latch_r;
      PULSE_SYNC: req_hold = fault_lost_sync;
      default: req_hold = stop_on_fault_bit ? fault_temp_warn
                                            : fault_over_temp;
    endcase
  end

  always_comb begin
    fp_nxt = fp_r;
    fp_len_nxt = fp_len_r;
    fp_cnt_nxt = fp_cnt_r;
    unique case (fp_r)
      FP_IDLE: begin
        if (req_new & ~perm_low) begin
          fp_nxt = FP_LOW;
          fp_len_nxt = req_len;
          fp_cnt_nxt = req_len;
        end
      end
      FP_LOW: begin
        if (pwm_rise) begin
          if (fp_cnt_r != 3'h0) begin
            fp_cnt_nxt = fp_cnt_r - 3'h1;
          end else if (req_rep & req_hold) begin
            fp_nxt = FP_GAP;
            fp_cnt_nxt = fp_len_r - 3'h1;
          end else begin
            fp_nxt = FP_IDLE;
          end
        end
      end
      FP_GAP: begin
        if (pwm_rise) begin
          if (fp_cnt_r != 3'h0) begin
            fp_cnt_nxt = fp_cnt_r - 3'h1;
          end else if (req_hold) begin
            fp_nxt = FP_LOW;
            fp_cnt_nxt = fp_len_r - 3'h1;
          end else begin
            fp_nxt = FP_IDLE;
          end
        end
      end
    endcase
  end

  always_comb begin
    if (mode == MODE_DIRECT) begin
      oe_nxt = direct_low;
    end else begin
      oe_nxt = perm_low | (fp_nxt == FP_LOW);
    end
  end

  // register access
  always_comb begin
    ctrl_nxt = ctrl_r;
    cfg_nxt = cfg_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: ctrl_nxt = reg_wdata[5:0];
        ADDR_CFG: cfg_nxt = reg_wdata[12:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: rdata_nxt = {26'h0, ctrl_r};
        ADDR_CFG: rdata_nxt = {19'h0, cfg_r};
        ADDR_STATUS: rdata_nxt = {16'h0000, bridge_drive, gate_disable,
                                  short_latch_r, fault_out_n_oe,
                                  ilim_threshold, duty8};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // output flops
  logic drive_r, hs_r, ls_r, fast_r, gdis_r, blank_o_r, oe_r;
  logic [3:0] thr_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= CTRL_RESET;
      cfg_r <= CFG_RESET;
      rdata_r <= 32'h0000_0000;
      pwm_d_r <= 1'b0;
      per_cnt_r <= '0;
      hi_cnt_r <= '0;
      short_latch_r <= 1'b0;
      short_d_r <= 1'b0;
      br_r <= BR_OFF;
      off_cnt_r <= 10'h000;
      fix_cnt_r <= 10'h000;
      blank_cnt_r <= 6'h00;
      fp_r <= FP_IDLE;
      fp_len_r <= PULSE_SHORT;
      fp_cnt_r <= 3'h0;
      drive_r <= 1'b0;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      fast_r <= 1'b0;
      gdis_r <= 1'b0;
      thr_r <= 4'h0;
      blank_o_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
      pwm_d_r <= pwm_s;
      per_cnt_r <= per_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      short_latch_r <= short_latch_nxt;
      short_d_r <= fault_short;
      br_r <= br_nxt;
      off_cnt_r <= off_cnt_nxt;
      fix_cnt_r <= fix_cnt_nxt;
      blank_cnt_r <= blank_cnt_nxt;
      fp_r <= fp_nxt;
      fp_len_r <= fp_len_nxt;
      fp_cnt_r <= fp_cnt_nxt;
      drive_r <= (br_nxt == BR_DRIVE);
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
      fast_r <= fast_nxt;
      gdis_r <= gate_dis_nxt;
      thr_r <= thr_nxt;
      blank_o_r <= (blank_cnt_nxt != 6'h00);
      oe_r <= oe_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign bridge_drive = drive_r;
  assign recirc_high = hs_r;
  assign recirc_low = ls_r;
  assign recirc_fast = fast_r;
  assign gate_disable = gdis_r;
  assign ilim_threshold = thr_r;
  assign ds_blank = blank_o_r;
  // open drain: only ever pulls low, released when enable is low
  assign fault_out_n_o = 1'b0;
  assign fault_out_n_oe = oe_r;
endmodule

// File: clp_current_limit_chk_props.sv
`timescale 1ns/1ps
module clp_current_limit_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic ilim_cmp_in,
  input wire logic fault_short,
  input wire logic fault_undervolt,
  input wire logic bridge_drive,
  input wire logic recirc_high,
  input wire logic recirc_low,
  input wire logic recirc_fast,
  input wire logic gate_disable,
  input wire logic ds_blank,
  input wire logic fault_out_n_o,
  input wire logic fault_out_n_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_od_data_low: assert property (fault_out_n_o == 1'b0)
    else $error("fault pin data not low");
  a_path_onehot: assert property (
    $onehot0({recirc_high, recirc_low, recirc_fast}))
    else $error("more than one recirculation path");
  a_drive_no_recirc: assert property (
    bridge_drive |-> !(recirc_high || recirc_low || recirc_fast))
    else $error("drive and recirculation together");
  a_gate_off_idle: assert property (gate_disable |-> !bridge_drive)
    else $error("bridge driven while gates disabled");
  a_short_pulls_low: assert property (
    $rose(fault_short) |=> fault_out_n_oe)
    else $error("short did not pull fault pin low");
  a_uv_steady_low: assert property (
    fault_undervolt |=> fault_out_n_oe)
    else $error("undervoltage not steady low");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_trip_ends_drive: assert property (
    (bridge_drive && !ds_blank && ilim_cmp_in) [*3] |=> !bridge_drive)
    else $error("overcurrent did not end drive");
endmodule

bind clp_current_limit clp_current_limit_chk u_chk (
  .mclk, .reset_n, .reg_rd, .reg_rdata, .ilim_cmp_in, .fault_short,
  .fault_undervolt, .bridge_drive, .recirc_high, .recirc_low,
  .recirc_fast, .gate_disable, .ds_blank, .fault_out_n_o, .fault_out_n_oe
);

// File: clp_pwm_src.sv
`timescale 1ns/1ps
// controller side pwm source; held low when high time is zero
module clp_pwm_src (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [15:0] period,
  input wire logic [15:0] high,
  output logic pwm
);
  logic [15:0] cnt_r, cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r + 16'h0001;
    if (cnt_nxt >= period) cnt_nxt = 16'h0000;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 16'h0000;
    else cnt_r <= cnt_nxt;
  end
  assign pwm = (cnt_r < high);
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import clp_pkg::*;
  logic mclk, reset_n, reg_wr, reg_rd, pwm_in, ilim_cmp_in, recirc_hs_pref;
  logic fault_short, fault_lost_sync, fault_over_temp, fault_temp_warn;
  logic fault_undervolt, serial_read_done, bridge_drive, recirc_high;
  logic recirc_low, recirc_fast, gate_disable, ds_blank;
  logic fault_out_n_o, fault_out_n_oe;
  logic [3:0] reg_addr, ilim_threshold;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] pwm_per, pwm_hi;
  int failures, n_checks, n;
  time t0;
  // pin has a pull-up; low only while the block enables its driver
  wire fault_pin = fault_out_n_oe ? fault_out_n_o : 1'b1;

  clp_current_limit #(.PER_W(10)) u_dut (.mclk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pwm_in, .ilim_cmp_in,
    .recirc_hs_pref, .fault_short, .fault_lost_sync, .fault_over_temp,
    .fault_temp_warn, .fault_undervolt, .serial_read_done, .bridge_drive,
    .recirc_high, .recirc_low, .recirc_fast, .gate_disable, .ilim_threshold,
    .ds_blank, .fault_out_n_o, .fault_out_n_oe);
  clp_pwm_src u_src (.mclk, .reset_n, .period(pwm_per), .high(pwm_hi),
    .pwm(pwm_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge mclk);
  endtask
  function automatic logic sig(int k);
    case (k)
      0: return bridge_drive;
      1: return ds_blank;
      2: return pwm_in;
      default: return recirc_high | recirc_low | recirc_fast;
    endcase
  endfunction
  task automatic wait_sig(int k, logic v, int lim);
    int i;
    i = 0;
    while (sig(k) !== v) begin
      @(negedge mclk);
      i++;
      if (i > lim) begin
        chk($sformatf("wait on signal %0d", k), sig(k), v);
        stop_test();
      end
    end
  endtask
  task automatic count_sig(int k, output int c);
    c = 0;
    while (sig(k) === 1'b1 && c < 5000) begin
      @(negedge mclk);
      c++;
    end
    if (c >= 5000) begin
      chk($sformatf("count on signal %0d", k), c, 0);
      stop_test();
    end
  endtask
  task automatic wait_rises(int k);
    repeat (k) begin
      wait_sig(2, 1'b0, 600);
      wait_sig(2, 1'b1, 600);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask
  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    cyc(1);
  endtask

  task automatic t_regs();
    rd(ADDR_CTRL, d);
    chk("ctrl reset", d, 32'h0);
    rd(ADDR_CFG, d);
    chk("cfg reset", d, 32'h0);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, d);
    chk("unmapped read", d, 32'h0);
    wr(ADDR_CTRL, 32'h0000003A);
    rd(ADDR_CTRL, d);
    chk("ctrl readback", d, 32'h0000003A);
    wr(ADDR_CFG, 32'hFFFFFFFF);
    rd(ADDR_CFG, d);
    chk("cfg readback", d, 32'h00001FFF);
    wr(ADDR_CTRL, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_level();
    int lv[3] = '{0, 11, 15};
    foreach (lv[i]) begin
      wr(ADDR_CFG, lv[i]);
      cyc(2);
      chk("level threshold", ilim_threshold, lv[i]);
    end
    $display("test level done");
  endtask
  task automatic t_duty();
    int hi[2] = '{200, 450};
    int du[2] = '{102, 230};
    wr(ADDR_CTRL, 32'h3);
    foreach (hi[i]) begin
      @(posedge mclk);
      pwm_hi <= hi[i];
      cyc(1200);
      rd(ADDR_STATUS, d);
      chk("duty8", d[7:0], du[i]);
      chk("duty threshold", ilim_threshold, du[i] / 16);
    end
    $display("test duty done");
  endtask
  task automatic t_recirc();
    logic [2:0] px[5] = '{3'b100, 3'b100, 3'b010, 3'b001, 3'b010};
    wr(ADDR_CFG, (3 << 9) | (2 << 4));
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      recirc_hs_pref <= (i != 4);
      // stop first so every pass sees a fresh drive entry and full blank
      wr(ADDR_CTRL, 32'h3);
      wr(ADDR_CTRL, 32'h7 | ((i % 4) << 4));
      wait_sig(0, 1'b1, 400);
      count_sig(1, n);
      chk("blank cycles", n, 12);
      @(posedge mclk);
      ilim_cmp_in <= 1'b1;
      wait_sig(0, 1'b0, 8);
      chk("path", {recirc_high, recirc_low, recirc_fast}, px[i]);
      @(posedge mclk);
      ilim_cmp_in <= 1'b0;
      count_sig(3, n);
      chk("off cycles", n, OFF_BASE_CYC + 2 * OFF_STEP_CYC);
      chk("drive after off-time", bridge_drive, 1'b1);
    end
    $display("test recirculation done");
  endtask
  task automatic t_period();
    wr(ADDR_CFG, (1 << 9) | (1 << 4));
    @(posedge mclk);
    ilim_cmp_in <= 1'b1;
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_CTRL, m | 4);
      wait_sig(0, 1'b0, 400);
      wait_sig(0, 1'b1, 400);
      t0 = $time;
      count_sig(1, n);
      chk("blank cycles", n, BLANK_STEP_CYC);
      chk("drive through blank", bridge_drive, 1'b1);
      wait_sig(0, 1'b0, 8);
      wait_sig(0, 1'b1, 400);
      chk("fixed period", ($time - t0) / 100, 216);
    end
    @(posedge mclk);
    ilim_cmp_in <= 1'b0;
    $display("test fixed period done");
  endtask
  task automatic t_direct();
    do_reset();
    pwm_per <= 16'd100;
    pwm_hi <= 16'd50;
    chk("pin released", fault_pin, 1'b1);
    @(posedge mclk);
    fault_undervolt <= 1'b1;
    cyc(3);
    chk("direct fault low", fault_pin, 1'b0);
    @(posedge mclk);
    fault_undervolt <= 1'b0;
    cyc(3);
    chk("direct released", fault_pin, 1'b1);
    $display("test direct fault done");
  endtask
  task automatic t_pulse(logic [2:0] f, logic [31:0] ctl, int np, bit rep);
    do_reset();
    wr(ADDR_CTRL, ctl);
    wait_rises(1);
    cyc(10);
    @(posedge mclk);
    {fault_short, fault_lost_sync, fault_temp_warn} <= f;
    cyc(2);
    chk("pulse start", fault_pin, 1'b0);
    wait_rises(np);
    cyc(40);
    chk("pulse held", fault_pin, 1'b0);
    wait_rises(1);
    cyc(5);
    chk("pulse end", fault_pin, 1'b1);
    if (rep) begin
      wait_rises(np - 1);
      cyc(40);
      chk("gap held", fault_pin, 1'b1);
      wait_rises(1);
      cyc(5);
      chk("pulse repeat", fault_pin, 1'b0);
    end
    @(posedge mclk);
    {fault_short, fault_lost_sync, fault_temp_warn} <= 3'b000;
    $display("test pulse %0d done", np);
  endtask
  task automatic t_stop();
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      fault_short <= 1'b1;
      cyc(3);
      @(posedge mclk);
      fault_short <= 1'b0;
      cyc(2);
      chk("gates off", gate_disable, 1'b1);
      rd(ADDR_STATUS, d);
      chk("short latched", d[13], 1'b1);
      @(posedge mclk);
      if (k == 0) serial_read_done <= 1'b1;
      else pwm_hi <= 16'd0;
      @(posedge mclk);
      serial_read_done <= 1'b0;
      cyc(k == 0 ? 2 : 2200);
      chk("gates restored", gate_disable, 1'b0);
    end
    @(posedge mclk);
    fault_over_temp <= 1'b1;
    cyc(3);
    chk("over temp low", fault_pin, 1'b0);
    chk("over temp gates", gate_disable, 1'b1);
    @(posedge mclk);
    fault_over_temp <= 1'b0;
    cyc(3);
    chk("over temp gates back", gate_disable, 1'b0);
    $display("test stop on fault done");
  endtask

  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, ilim_cmp_in, recirc_hs_pref, serial_read_done} = 5'h00;
    {fault_short, fault_lost_sync, fault_over_temp} = 3'h0;
    {fault_temp_warn, fault_undervolt} = 2'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    pwm_per = 16'd500;
    pwm_hi = 16'd200;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    cyc(1);
    t_regs();
    t_level();
    t_duty();
    t_recirc();
    t_period();
    t_direct();
    t_pulse(3'b100, 32'h1, 2, 1'b0);
    t_pulse(3'b010, 32'h1, 3, 1'b1);
    t_pulse(3'b001, 32'h9, 4, 1'b1);
    t_stop();
    stop_test();
  end
endmodule
